/* rtl/vg_defs.svh */
`ifndef VG_DEFS_SVH
`define VG_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define VG_OFS_CHROMA_UPPER 8'h2d
`define VG_OFS_CHROMA_LOWER 8'h2e
`define VG_OFS_LUMA_UPPER 8'h2f
`define VG_OFS_LUMA_LOWER 8'h30
`define VG_OFS_SHADOW_UPPER 8'h31
`define VG_OFS_SHADOW_LOWER 8'h32
`define VG_OFS_MISC 8'h33
`define VG_OFS_SYNC_UPPER 8'h34
`define VG_OFS_SYNC_BEGIN_LOWER 8'h35
`define VG_OFS_SYNC_END_LOWER 8'h36

// ************************************************************
// field positions
// ************************************************************
`define VG_SPEED_HI 7
`define VG_SPEED_LO 6
`define VG_SURV_BIT 7
`define VG_PW_RATE_BIT 0
`define VG_LINE_RANGE_BIT 1
`define VG_MAX_LEVEL_HI 4
`define VG_MAX_LEVEL_LO 2
`define VG_COLOR_KILL_BIT 6
`define VG_SYNC_BEGIN_HI 7
`define VG_SYNC_BEGIN_LO 6
`define VG_SYNC_END_HI 5
`define VG_SYNC_END_LO 4

// ************************************************************
// reset values and fixed bits
// ************************************************************
`define VG_RST_GAIN 12'h000
`define VG_RST_SPEED 2'h0
`define VG_RST_MISC_BITS 1'h0
`define VG_RST_MAX_LEVEL 3'h0
`define VG_RST_SYNC_BEGIN 10'h001
`define VG_RST_SYNC_END 10'h000
`define VG_ONES_GAIN_UPPER 8'h30
`define VG_ONES_SHADOW_UPPER 8'h70
`define VG_ONES_MISC 8'ha0
`define VG_ONES_SYNC_UPPER 8'h0f

// ************************************************************
// mode codes and line range
// ************************************************************
`define VG_CHROMA_AUTO 2'h2
`define VG_LUMA_MANUAL 3'h0
`define VG_LUMA_PEAK 3'h5
`define VG_LUMA_AVERAGE 3'h6
`define VG_LUMA_FREEZE 3'h7
`define VG_LINE_FIRST 10'h021
`define VG_LINE_LAST_LONG 10'h136
`define VG_LINE_LAST_SHORT 10'h10e

// ************************************************************
// tracking time constants
// ************************************************************
`define VG_CLK_KHZ 25000
`define VG_TC_SLOW_MS 2000
`define VG_TC_MEDIUM_MS 1000
`define VG_TC_FAST_MS 200

`endif

/* rtl/vg_pkg.sv */
package vg_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vg_bus_req_t;

    typedef struct packed {
        logic [11:0] manual_gain;
        logic [1:0] speed;
        logic track_tick;
    } vg_gain_cfg_t;

    typedef enum logic [1:0] {
        VG_SPEED_SLOW = 2'b00,
        VG_SPEED_MEDIUM = 2'b01,
        VG_SPEED_FAST = 2'b10,
        VG_SPEED_QUALITY = 2'b11
    } vg_speed_t;

endpackage

/* rtl/vg_regs.sv */
`timescale 1ns/1ps
`include "vg_defs.svh"

module vg_regs #(
    parameter int TC_SLOW_CYC = `VG_TC_SLOW_MS * `VG_CLK_KHZ,
    parameter int TC_MEDIUM_CYC = `VG_TC_MEDIUM_MS * `VG_CLK_KHZ,
    parameter int TC_FAST_CYC = `VG_TC_FAST_MS * `VG_CLK_KHZ
) (
    input wire logic core_clk,
    input wire logic rst,
    input vg_pkg::vg_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic [1:0] chroma_gain_mode,
    input wire logic [2:0] luma_gain_mode,
    input wire logic [11:0] chroma_gain_used,
    input wire logic [11:0] luma_gain_used,
    input wire logic [1:0] video_quality_measure,
    input wire logic is_pal,
    input wire logic line_start,
    input wire logic field_start,
    input wire logic [9:0] line_number,
    input wire logic hsync_ref,
    input wire logic pix_en,
    output vg_pkg::vg_gain_cfg_t chroma_cfg,
    output vg_pkg::vg_gain_cfg_t luma_cfg,
    output logic luma_update,
    output logic avg_measure_en,
    output logic [7:0] max_input_level,
    output logic color_kill_en,
    output logic surveillance_update_enable,
    output logic hsync_out
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [25:0] tc_period(input logic [1:0] speed, input logic [1:0] qual);
        logic [1:0] sel;
        sel = (speed == vg_pkg::VG_SPEED_QUALITY) ? ((qual > 2'h2) ? 2'h2 : qual) : speed;
        case (sel)
            2'h0: tc_period = 26'(TC_SLOW_CYC - 1);
            2'h1: tc_period = 26'(TC_MEDIUM_CYC - 1);
            default: tc_period = 26'(TC_FAST_CYC - 1);
        endcase
    endfunction

    function automatic logic [7:0] level_limit(input logic [2:0] code, input logic pal);
        case (code)
            3'h0: level_limit = pal ? 8'h85 : 8'h7a;
            3'h1: level_limit = pal ? 8'h7d : 8'h73;
            3'h2: level_limit = pal ? 8'h78 : 8'h6e;
            3'h3: level_limit = pal ? 8'h73 : 8'h69;
            3'h4: level_limit = pal ? 8'h6e : 8'h64;
            3'h5: level_limit = pal ? 8'h69 : 8'h64;
            default: level_limit = 8'h64;
        endcase
    endfunction

    // ************************************************************
    // register storage
    // ************************************************************
    logic [11:0] chroma_manual_gain;
    logic [1:0] chroma_gain_speed;
    logic [11:0] luma_manual_gain;
    logic [1:0] luma_gain_speed;
    logic [11:0] luma_shadow_gain;
    logic shadow_pending;
    logic peak_white_update_rate;
    logic brightness_line_range;
    logic [2:0] max_input_code;
    logic [9:0] sync_begin_position;
    logic [9:0] sync_end_position;
    logic wr_hit;
    logic shadow_load;
    logic chroma_auto;
    logic luma_auto;

    assign wr_hit = bus_req.wr;
    assign chroma_auto = (chroma_gain_mode == `VG_CHROMA_AUTO);
    assign luma_auto = (luma_gain_mode != `VG_LUMA_MANUAL) && (luma_gain_mode != `VG_LUMA_FREEZE);
    // shadow copy waits for a field boundary so the gain never steps mid-picture
    assign shadow_load = shadow_pending && field_start && surveillance_update_enable
        && (luma_gain_mode == `VG_LUMA_MANUAL);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            chroma_manual_gain <= `VG_RST_GAIN;
            chroma_gain_speed <= `VG_RST_SPEED;
        end else if (wr_hit && bus_req.addr == `VG_OFS_CHROMA_UPPER) begin
            chroma_manual_gain[11:8] <= bus_req.wdata[3:0];
            chroma_gain_speed <= bus_req.wdata[`VG_SPEED_HI:`VG_SPEED_LO];
        end else if (wr_hit && bus_req.addr == `VG_OFS_CHROMA_LOWER) begin
            chroma_manual_gain[7:0] <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            luma_manual_gain <= `VG_RST_GAIN;
            luma_gain_speed <= `VG_RST_SPEED;
        end else if (wr_hit && bus_req.addr == `VG_OFS_LUMA_UPPER) begin
            luma_manual_gain[11:8] <= bus_req.wdata[3:0];
            luma_gain_speed <= bus_req.wdata[`VG_SPEED_HI:`VG_SPEED_LO];
        end else if (wr_hit && bus_req.addr == `VG_OFS_LUMA_LOWER) begin
            luma_manual_gain[7:0] <= bus_req.wdata;
        end else if (shadow_load) begin
            luma_manual_gain <= luma_shadow_gain;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            luma_shadow_gain <= `VG_RST_GAIN;
            surveillance_update_enable <= `VG_RST_MISC_BITS;
        end else if (wr_hit && bus_req.addr == `VG_OFS_SHADOW_UPPER) begin
            luma_shadow_gain[11:8] <= bus_req.wdata[3:0];
            surveillance_update_enable <= bus_req.wdata[`VG_SURV_BIT];
        end else if (wr_hit && bus_req.addr == `VG_OFS_SHADOW_LOWER) begin
            luma_shadow_gain[7:0] <= bus_req.wdata;
        end
    end

    // a new lower-byte write wins over the load that consumes the old one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shadow_pending <= 1'b0;
        end else if (wr_hit && bus_req.addr == `VG_OFS_SHADOW_LOWER) begin
            shadow_pending <= 1'b1;
        end else if (shadow_load) begin
            shadow_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            peak_white_update_rate <= `VG_RST_MISC_BITS;
            brightness_line_range <= `VG_RST_MISC_BITS;
            max_input_code <= `VG_RST_MAX_LEVEL;
            color_kill_en <= `VG_RST_MISC_BITS;
        end else if (wr_hit && bus_req.addr == `VG_OFS_MISC) begin
            peak_white_update_rate <= bus_req.wdata[`VG_PW_RATE_BIT];
            brightness_line_range <= bus_req.wdata[`VG_LINE_RANGE_BIT];
            max_input_code <= bus_req.wdata[`VG_MAX_LEVEL_HI:`VG_MAX_LEVEL_LO];
            color_kill_en <= bus_req.wdata[`VG_COLOR_KILL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_begin_position <= `VG_RST_SYNC_BEGIN;
            sync_end_position <= `VG_RST_SYNC_END;
        end else if (wr_hit && bus_req.addr == `VG_OFS_SYNC_UPPER) begin
            sync_begin_position[9:8] <= bus_req.wdata[`VG_SYNC_BEGIN_HI:`VG_SYNC_BEGIN_LO];
            sync_end_position[9:8] <= bus_req.wdata[`VG_SYNC_END_HI:`VG_SYNC_END_LO];
        end else if (wr_hit && bus_req.addr == `VG_OFS_SYNC_BEGIN_LOWER) begin
            sync_begin_position[7:0] <= bus_req.wdata;
        end else if (wr_hit && bus_req.addr == `VG_OFS_SYNC_END_LOWER) begin
            sync_end_position[7:0] <= bus_req.wdata;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // gain registers read the gain in use, not what was written
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `VG_OFS_CHROMA_UPPER: rd_data <= {chroma_gain_speed, 2'h0, chroma_gain_used[11:8]}
                    | `VG_ONES_GAIN_UPPER;
                `VG_OFS_CHROMA_LOWER: rd_data <= chroma_gain_used[7:0];
                `VG_OFS_LUMA_UPPER: rd_data <= {luma_gain_speed, 2'h0, luma_gain_used[11:8]}
                    | `VG_ONES_GAIN_UPPER;
                `VG_OFS_LUMA_LOWER: rd_data <= luma_gain_used[7:0];
                `VG_OFS_SHADOW_UPPER: rd_data <= {surveillance_update_enable, 3'h0,
                    luma_gain_used[11:8]} | `VG_ONES_SHADOW_UPPER;
                `VG_OFS_SHADOW_LOWER: rd_data <= luma_gain_used[7:0];
                `VG_OFS_MISC: rd_data <= {2'h0, color_kill_en, max_input_code,
                    brightness_line_range, peak_white_update_rate} | `VG_ONES_MISC;
                `VG_OFS_SYNC_UPPER: rd_data <= {sync_begin_position[9:8],
                    sync_end_position[9:8], 4'h0} | `VG_ONES_SYNC_UPPER;
                `VG_OFS_SYNC_BEGIN_LOWER: rd_data <= sync_begin_position[7:0];
                `VG_OFS_SYNC_END_LOWER: rd_data <= sync_end_position[7:0];
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ************************************************************
    // tracking tick dividers
    // ************************************************************
    logic [25:0] chroma_div;
    logic [25:0] luma_div;
    logic chroma_tick;
    logic luma_tick;

    // divider held in reset outside auto mode so a mode change starts a clean period
    always_ff @(posedge core_clk) begin
        if (rst || !chroma_auto) begin
            chroma_div <= 26'h0;
            chroma_tick <= 1'b0;
        end else if (chroma_div >= tc_period(chroma_gain_speed, video_quality_measure)) begin
            chroma_div <= 26'h0;
            chroma_tick <= 1'b1;
        end else begin
            chroma_div <= chroma_div + 26'h1;
            chroma_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !luma_auto) begin
            luma_div <= 26'h0;
            luma_tick <= 1'b0;
        end else if (luma_div >= tc_period(luma_gain_speed, video_quality_measure)) begin
            luma_div <= 26'h0;
            luma_tick <= 1'b1;
        end else begin
            luma_div <= luma_div + 26'h1;
            luma_tick <= 1'b0;
        end
    end

    assign chroma_cfg = '{manual_gain: chroma_manual_gain, speed: chroma_gain_speed,
        track_tick: chroma_tick};
    assign luma_cfg = '{manual_gain: luma_manual_gain, speed: luma_gain_speed,
        track_tick: luma_tick};

    // ************************************************************
    // measurement controls
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            luma_update <= 1'b0;
            avg_measure_en <= 1'b0;
            max_input_level <= 8'h00;
        end else begin
            luma_update <= (luma_gain_mode == `VG_LUMA_PEAK || luma_gain_mode == `VG_LUMA_AVERAGE)
                && (peak_white_update_rate ? field_start : line_start);
            avg_measure_en <= (line_number >= `VG_LINE_FIRST) && (line_number <=
                (brightness_line_range ? `VG_LINE_LAST_SHORT : `VG_LINE_LAST_LONG));
            max_input_level <= level_limit(max_input_code, is_pal);
        end
    end

    // ************************************************************
    // sync output placement
    // ************************************************************
    logic hsync_ref_prev;
    logic [9:0] pix_count;
    logic counting;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hsync_ref_prev <= 1'b0;
            pix_count <= 10'h0;
            counting <= 1'b0;
        end else begin
            hsync_ref_prev <= hsync_ref;
            if (hsync_ref_prev && !hsync_ref) begin
                pix_count <= 10'h0;
                counting <= 1'b1;
            end else if (counting && pix_en) begin
                // count stops at 1023; a line longer than 1023 pixels clears counting, which forces hsync_out low
                if (pix_count == 10'h3ff) begin
                    counting <= 1'b0;
                end else begin
                    pix_count <= pix_count + 10'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hsync_out <= 1'b0;
        end else begin
            hsync_out <= counting && (pix_count >= sync_begin_position)
                && (pix_count < sync_end_position);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chroma_tick_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        chroma_tick |-> $past(chroma_auto)) else $error("chroma tick outside auto mode");
    luma_tick_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        luma_tick |-> $past(luma_auto)) else $error("luma tick outside auto mode");
    chroma_lower_wr_a: assert property (@(posedge core_clk) disable iff (rst)
        bus_req.wr && bus_req.addr == `VG_OFS_CHROMA_LOWER |=> chroma_cfg.manual_gain[7:0]
        == $past(bus_req.wdata)) else $error("chroma lower byte not stored");
    gain_readback_a: assert property (@(posedge core_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == `VG_OFS_LUMA_LOWER |=> rd_data == $past(luma_gain_used[7:0]))
        else $error("luma readback not gain in use");
    shadow_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        !surveillance_update_enable && !(bus_req.wr && (bus_req.addr == `VG_OFS_LUMA_UPPER
        || bus_req.addr == `VG_OFS_LUMA_LOWER)) |=> $stable(luma_cfg.manual_gain))
        else $error("shadow update while disabled");
    update_rate_a: assert property (@(posedge core_clk) disable iff (rst)
        luma_update |-> $past(peak_white_update_rate ? field_start : line_start))
        else $error("luma update at wrong rate");
    line_range_a: assert property (@(posedge core_clk) disable iff (rst)
        ##1 $past(line_number) == 10'h137 |-> !avg_measure_en)
        else $error("line 311 inside brightness window");
    level_pal_a: assert property (@(posedge core_clk) disable iff (rst)
        max_input_code == 3'h0 && is_pal ##1 max_input_code == 3'h0 |-> max_input_level == 8'h85)
        else $error("max level code 0 not 133 for pal");
    sync_window_a: assert property (@(posedge core_clk) disable iff (rst)
        hsync_out |-> $past(pix_count) >= $past(sync_begin_position) && $past(counting))
        else $error("sync output before begin position");

endmodule

/* test/vg_regs_tb.sv */
`timescale 1ns/1ps
`include "vg_defs.svh"

module tb;
    // ************************************************************
    // stimulus, design and counters
    // ************************************************************
    typedef struct packed {
        logic luma;
        logic [2:0] mode;
        logic [1:0] speed;
        logic [1:0] qual;
        logic [7:0] win;
        logic [7:0] exp;
    } vg_tick_case_t;
    // short time constants keep the run brief
    localparam vg_tick_case_t TICKS [13] = '{
        '{1'b0, 3'h2, 2'h2, 2'h0, 8'h28, 8'h0a}, '{1'b0, 3'h2, 2'h1, 2'h0, 8'h28, 8'h02},
        '{1'b0, 3'h2, 2'h0, 2'h0, 8'h50, 8'h02}, '{1'b0, 3'h2, 2'h3, 2'h1, 8'h28, 8'h02},
        '{1'b0, 3'h2, 2'h3, 2'h2, 8'h28, 8'h0a}, '{1'b0, 3'h0, 2'h2, 2'h0, 8'h28, 8'h00},
        '{1'b0, 3'h3, 2'h2, 2'h0, 8'h28, 8'h00}, '{1'b1, 3'h5, 2'h2, 2'h0, 8'h28, 8'h0a},
        '{1'b1, 3'h6, 2'h3, 2'h0, 8'h50, 8'h02}, '{1'b1, 3'h0, 2'h2, 2'h0, 8'h28, 8'h00},
        '{1'b1, 3'h7, 2'h2, 2'h0, 8'h28, 8'h00},
        '{1'b0, 3'h1, 2'h2, 2'h0, 8'h28, 8'h00}, '{1'b1, 3'h2, 2'h2, 2'h0, 8'h28, 8'h0a}};
    localparam logic [7:0] PAL_LVL [8] = '{8'h85, 8'h7d, 8'h78, 8'h73, 8'h6e, 8'h69, 8'h64, 8'h64};
    localparam logic [7:0] NTSC_LVL [8] = '{8'h7a, 8'h73, 8'h6e, 8'h69,
        8'h64, 8'h64, 8'h64, 8'h64};
    localparam logic [7:0] RST_ADDR [12] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33,
        8'h34, 8'h35, 8'h36, 8'h37, 8'h2c};
    localparam logic [7:0] RST_EXP [12] = '{8'h35, 8'ha3, 8'h33, 8'hc7, 8'h73, 8'hc7, 8'ha0,
        8'h0f, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [9:0] LINES [6] = '{10'd32, 10'd33, 10'd270, 10'd271, 10'd310, 10'd311};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    vg_pkg::vg_bus_req_t bus_req = '0;
    logic [7:0] rd_data;
    logic [1:0] chroma_gain_mode = 2'h0;
    logic [2:0] luma_gain_mode = 3'h0;
    logic [11:0] chroma_gain_used = 12'h5a3;
    logic [11:0] luma_gain_used = 12'h3c7;
    logic [1:0] video_quality_measure = 2'h0;
    logic is_pal = 1'b1;
    logic line_start = 1'b0;
    logic field_start = 1'b0;
    logic [9:0] line_number = 10'h000;
    logic hsync_ref = 1'b0;
    logic pix_en = 1'b0;
    vg_pkg::vg_gain_cfg_t chroma_cfg;
    vg_pkg::vg_gain_cfg_t luma_cfg;
    logic luma_update;
    logic avg_measure_en;
    logic [7:0] max_input_level;
    logic color_kill_en;
    logic surveillance_update_enable;
    logic hsync_out;
    int n_errors = 0;
    int cmp_count = 0;
    int k;

    always #20 core_clk = ~core_clk;

    vg_regs #(.TC_SLOW_CYC(40), .TC_MEDIUM_CYC(20), .TC_FAST_CYC(4)) dut (
        .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .chroma_gain_mode(chroma_gain_mode), .luma_gain_mode(luma_gain_mode),
        .chroma_gain_used(chroma_gain_used), .luma_gain_used(luma_gain_used),
        .video_quality_measure(video_quality_measure), .is_pal(is_pal),
        .line_start(line_start), .field_start(field_start), .line_number(line_number),
        .hsync_ref(hsync_ref), .pix_en(pix_en), .chroma_cfg(chroma_cfg), .luma_cfg(luma_cfg),
        .luma_update(luma_update), .avg_measure_en(avg_measure_en),
        .max_input_level(max_input_level), .color_kill_en(color_kill_en),
        .surveillance_update_enable(surveillance_update_enable), .hsync_out(hsync_out));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge core_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(12'(rd_data), 12'(exp), msg);
    endtask

    // one line or field strobe, then the update pulse one cycle later
    task automatic strobe(input logic field, input logic exp, input string msg);
        @(posedge core_clk);
        field_start <= field;
        line_start <= ~field;
        @(posedge core_clk);
        field_start <= 1'b0;
        line_start <= 1'b0;
        #1;
        chk(12'(luma_update), 12'(exp), msg);
    endtask

    task automatic sync_run(input logic [9:0] b, input logic [9:0] e);
        int w;
        w = 0;
        wr(`VG_OFS_SYNC_UPPER, {b[9:8], e[9:8], 4'hf});
        wr(`VG_OFS_SYNC_BEGIN_LOWER, b[7:0]);
        wr(`VG_OFS_SYNC_END_LOWER, e[7:0]);
        rd_chk(`VG_OFS_SYNC_UPPER, {b[9:8], e[9:8], 4'hf}, "sync upper");
        @(posedge core_clk);
        hsync_ref <= 1'b1;
        cycles(2);
        hsync_ref <= 1'b0;
        cycles(2);
        pix_en <= 1'b1;
        repeat (int'(e) + 10) begin
            @(posedge core_clk);
            #1;
            if (hsync_out === 1'b1) w++;
        end
        pix_en <= 1'b0;
        chk(12'(w), (e > b) ? 12'(e - b) : 12'h000, "sync width");
    endtask

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end

    initial begin
        cycles(2);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) rd_chk(RST_ADDR[i], RST_EXP[i], "reset read");
        cycles(1);
        #1;
        chk(12'(rd_data), 12'h000, "read data held");
        $display("test reset done");
        wr(`VG_OFS_CHROMA_UPPER, 8'hbc);
        wr(`VG_OFS_CHROMA_LOWER, 8'h55);
        wr(`VG_OFS_LUMA_UPPER, 8'h7b);
        wr(`VG_OFS_LUMA_LOWER, 8'h66);
        wr(8'h40, 8'hff);
        chk(chroma_cfg.manual_gain, 12'hc55, "chroma gain");
        chk(12'(chroma_cfg.speed), 12'h002, "chroma speed");
        chk(luma_cfg.manual_gain, 12'hb66, "luma gain");
        rd_chk(`VG_OFS_CHROMA_UPPER, 8'hb5, "chroma upper");
        rd_chk(`VG_OFS_LUMA_UPPER, 8'h73, "luma upper");
        rd_chk(8'h40, 8'h00, "unmapped");
        $display("test gains done");
        foreach (TICKS[i]) begin
            if (TICKS[i].luma) begin
                wr(`VG_OFS_LUMA_UPPER, {TICKS[i].speed, 6'h3b});
            end else begin
                wr(`VG_OFS_CHROMA_UPPER, {TICKS[i].speed, 6'h3c});
            end
            chroma_gain_mode <= TICKS[i].luma ? 2'h0 : TICKS[i].mode[1:0];
            luma_gain_mode <= TICKS[i].luma ? TICKS[i].mode : 3'h0;
            video_quality_measure <= TICKS[i].qual;
            cycles(3);
            count_ticks(TICKS[i].luma, int'(TICKS[i].win), k);
            chk(12'(k), 12'(TICKS[i].exp), "tick count");
        end
        @(posedge core_clk);
        chroma_gain_mode <= 2'h0;
        luma_gain_mode <= 3'h0;
        $display("test tracking done");
        wr(`VG_OFS_SHADOW_UPPER, 8'h7a);
        wr(`VG_OFS_SHADOW_LOWER, 8'h44);
        strobe(1'b1, 1'b0, "update manual");
        chk(luma_cfg.manual_gain, 12'hb66, "shadow blocked");
        chk(12'(surveillance_update_enable), 12'h000, "surv off");
        wr(`VG_OFS_SHADOW_UPPER, 8'hfa);
        wr(`VG_OFS_SHADOW_LOWER, 8'h44);
        strobe(1'b1, 1'b0, "update manual");
        chk(luma_cfg.manual_gain, 12'ha44, "shadow applied");
        chk(12'(surveillance_update_enable), 12'h001, "surv on");
        rd_chk(`VG_OFS_SHADOW_UPPER, 8'hf3, "shadow upper");
        rd_chk(`VG_OFS_SHADOW_LOWER, 8'hc7, "shadow lower");
        wr(`VG_OFS_SHADOW_LOWER, 8'h22);
        luma_gain_mode <= 3'h5;
        strobe(1'b1, 1'b0, "field at line rate");
        chk(luma_cfg.manual_gain, 12'ha44, "shadow outside manual");
        strobe(1'b0, 1'b1, "line at line rate");
        wr(`VG_OFS_MISC, 8'ha1);
        strobe(1'b0, 1'b0, "line at field rate");
        strobe(1'b1, 1'b1, "field at field rate");
        luma_gain_mode <= 3'h6;
        strobe(1'b1, 1'b1, "average mode");
        luma_gain_mode <= 3'h7;
        strobe(1'b1, 1'b0, "frozen mode");
        luma_gain_mode <= 3'h0;
        strobe(1'b1, 1'b0, "manual mode");
        chk(luma_cfg.manual_gain, 12'ha22, "pending shadow");
        $display("test shadow and update done");
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                wr(`VG_OFS_MISC, {3'h7, 3'(c), 2'h0});
                is_pal <= 1'(p);
                cycles(2);
                #1;
                chk(12'(max_input_level), 12'(p ? PAL_LVL[c] : NTSC_LVL[c]), "max level");
                chk(12'(color_kill_en), 12'h001, "kill on");
            end
        end
        wr(`VG_OFS_MISC, 8'ha0);
        rd_chk(`VG_OFS_MISC, 8'ha0, "misc read");
        chk(12'(color_kill_en), 12'h000, "kill off");
        for (int r = 0; r < 2; r++) begin
            wr(`VG_OFS_MISC, {6'h28, 1'(r), 1'b0});
            foreach (LINES[i]) begin
                line_number <= LINES[i];
                cycles(2);
                #1;
                chk(12'(avg_measure_en), 12'(LINES[i] >= 10'd33 &&
                    LINES[i] <= (r ? 10'd270 : 10'd310)), "line window");
            end
        end
        $display("test misc done");
        sync_run(10'd3, 10'd6);
        sync_run(10'h101, 10'h105);
        sync_run(10'd5, 10'd5);
        $display("test sync done");
        wrap_up();
    end

    task automatic count_ticks(input logic luma, input int n, output int t);
        t = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if ((luma ? luma_cfg.track_tick : chroma_cfg.track_tick) === 1'b1) t++;
        end
    endtask
endmodule
